// file: verilog/ilf_pkg.sv
package ilf_pkg;

  // ---------------------------------------------------------------------------
  // Bus geometry
  // ---------------------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int SEL_W  = 4;
  localparam int MAX_LINES = 32;

  // ---------------------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_FILT_EN   = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_FILT_DIS  = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_FILT_ST   = 8'h28;
  localparam logic [ADDR_W-1:0] OFS_DRV_SET   = 8'h30;
  localparam logic [ADDR_W-1:0] OFS_DRV_CLR   = 8'h34;
  localparam logic [ADDR_W-1:0] OFS_DRV_ST    = 8'h38;
  localparam logic [ADDR_W-1:0] OFS_PIN_ST    = 8'h3C;
  localparam logic [ADDR_W-1:0] OFS_IRQ_EN    = 8'h40;
  localparam logic [ADDR_W-1:0] OFS_IRQ_DIS   = 8'h44;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK  = 8'h48;
  localparam logic [ADDR_W-1:0] OFS_IRQ_FLAGS = 8'h4C;
  localparam logic [ADDR_W-1:0] OFS_OD_EN     = 8'h50;
  localparam logic [ADDR_W-1:0] OFS_OD_DIS    = 8'h54;
  localparam logic [ADDR_W-1:0] OFS_OD_ST     = 8'h58;
  localparam logic [ADDR_W-1:0] OFS_PERM_EN   = 8'hA0;
  localparam logic [ADDR_W-1:0] OFS_PERM_DIS  = 8'hA4;
  localparam logic [ADDR_W-1:0] OFS_PERM_ST   = 8'hA8;

  // ---------------------------------------------------------------------------
  // Reset values and read filler
  // ---------------------------------------------------------------------------
  localparam logic [DATA_W-1:0] RESET_ZERO  = 32'h0000_0000;
  localparam logic [DATA_W-1:0] UNMAPPED_RD = 32'h0000_0000;

  // ---------------------------------------------------------------------------
  // Carriers and states
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic              cyc;
    logic              stb;
    logic              we;
    logic [ADDR_W-1:0] adr;
    logic [SEL_W-1:0]  sel;
    logic [DATA_W-1:0] dat;
  } ilf_wb_req_s;

  typedef struct packed {
    logic              ack;
    logic [DATA_W-1:0] dat;
  } ilf_wb_rsp_s;

  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_ACK  = 1'b1
  } ilf_bus_e;

endpackage

// file: verilog/ilf_gpio_core.sv
// Local design decisions: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ns

// How it works
// - Every per-line register maps bit n to I/O line n, lines 0 to 31.
// - Ones written to filter-enable turn that line's glitch filter on.
// - Ones written to filter-disable turn that line's glitch filter off.
// - Filter state reads one for each line whose filter is on.
// - Ones written to drive-set make that line's driven level high.
// - Ones written to drive-clear make that line's driven level low.
// - Drive state reads the level currently scheduled per line.
// - Drive state is always readable, directly writable on permitted lines only.
// - Pin state reads the sampled logic level of each line.
// - Ones written to irq-enable enable that line's change interrupt.
// - Ones written to irq-disable disable that line's change interrupt.
// - Irq mask reads one for each line whose change interrupt is enabled.
// - A level change on a line sets its flag until the flags are read.
// - Reading the flags, or reset, clears them all.
// - Ones written to open-drain enable put that line in multi-drive.
// - Multi-drive lines are only driven low; others drive high and low.
module ilf_gpio_core #(
  parameter int LINES = 32
) (
  // Clock and reset
  input  logic                 mclk,
  input  logic                 rst,
  // Register bus
  input  ilf_pkg::ilf_wb_req_s wbReq,
  output ilf_pkg::ilf_wb_rsp_s wbRsp,
  // Pins and pin ownership
  input  logic [LINES-1:0]     pinIn,
  input  logic [LINES-1:0]     lineOutputEn,
  output logic [LINES-1:0]     pinOut,
  output logic [LINES-1:0]     pinOe,
  // Interrupt request
  output logic                 irq
);

  if (LINES < 1 || LINES > ilf_pkg::MAX_LINES) begin : g_bad_lines
    $error("LINES must be between 1 and 32");
  end

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef struct packed {
    ilf_pkg::ilf_bus_e           bus;
    logic [ilf_pkg::DATA_W-1:0]  rdat;
    logic [LINES-1:0]            syncA;
    logic [LINES-1:0]            syncB;
    logic [LINES-1:0]            prevS;
    logic [LINES-1:0]            level;
    logic [LINES-1:0]            filt;
    logic [LINES-1:0]            drive;
    logic [LINES-1:0]            perm;
    logic [LINES-1:0]            multi;
    logic [LINES-1:0]            imask;
    logic [LINES-1:0]            flags;
    logic [LINES-1:0]            pout;
    logic [LINES-1:0]            poe;
    logic                        irq;
  } ilf_state_s;

  ilf_state_s s_q;
  ilf_state_s s_d;

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  // Bits carried by one byte-lane select
  localparam int LANE_W = ilf_pkg::DATA_W / ilf_pkg::SEL_W;

  function automatic logic [LINES-1:0] laneMask(
    input logic [ilf_pkg::SEL_W-1:0] sel
  );
    logic [ilf_pkg::DATA_W-1:0] m;
    m = '0;
    for (int i = 0; i < ilf_pkg::SEL_W; i++) begin
      m[i*LANE_W +: LANE_W] = {LANE_W{sel[i]}};
    end
    return m[LINES-1:0];
  endfunction

  function automatic logic [ilf_pkg::DATA_W-1:0] widen(input logic [LINES-1:0] v);
    return ilf_pkg::DATA_W'(v);
  endfunction

  logic             access;
  logic             wrEdge;
  logic             rdEdge;
  logic [LINES-1:0] byteEn;
  logic [LINES-1:0] wl;
  logic [LINES-1:0] stableS;
  logic [LINES-1:0] newLevel;
  logic [LINES-1:0] change;
  logic             wrFiltEn;
  logic             wrFiltDis;
  logic             wrDrvSet;
  logic             wrDrvClr;
  logic             wrDrvSt;
  logic             wrIrqEn;
  logic             wrIrqDis;
  logic             wrOdEn;
  logic             rdFlags;

  // A write lands on the edge where ack is high; read data is captured one
  // edge earlier so that it is stable while ack stands.
  assign access   = wbReq.cyc & wbReq.stb;
  assign wrEdge   = access & wbReq.we & (s_q.bus == ilf_pkg::BUS_ACK);
  assign rdEdge   = access & ~wbReq.we & (s_q.bus == ilf_pkg::BUS_IDLE);
  assign byteEn   = laneMask(wbReq.sel);
  assign wl       = wbReq.dat[LINES-1:0] & byteEn;
  assign wrFiltEn = wrEdge && wbReq.adr == ilf_pkg::OFS_FILT_EN;
  assign wrFiltDis = wrEdge && wbReq.adr == ilf_pkg::OFS_FILT_DIS;
  assign wrDrvSet = wrEdge && wbReq.adr == ilf_pkg::OFS_DRV_SET;
  assign wrDrvClr = wrEdge && wbReq.adr == ilf_pkg::OFS_DRV_CLR;
  assign wrDrvSt  = wrEdge && wbReq.adr == ilf_pkg::OFS_DRV_ST;
  assign wrIrqEn  = wrEdge && wbReq.adr == ilf_pkg::OFS_IRQ_EN;
  assign wrIrqDis = wrEdge && wbReq.adr == ilf_pkg::OFS_IRQ_DIS;
  assign wrOdEn   = wrEdge && wbReq.adr == ilf_pkg::OFS_OD_EN;
  assign rdFlags  = rdEdge && wbReq.adr == ilf_pkg::OFS_IRQ_FLAGS;

  // ---------------------------------------------------------------------------
  // Input sampling and glitch filter
  // ---------------------------------------------------------------------------
  // A filtered line only follows the pin after two equal samples, so a pulse
  // of one clock is rejected at the cost of one cycle of extra latency.
  assign stableS  = ~(s_q.syncB ^ s_q.prevS);
  assign newLevel = (s_q.syncB & ~s_q.filt) |
                    (s_q.filt & ((s_q.syncB & stableS) | (s_q.level & ~stableS)));
  assign change   = newLevel ^ s_q.level;

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    // One ack per request; a request held on is answered every other cycle
    case (s_q.bus)
      ilf_pkg::BUS_IDLE: begin
        if (access) begin
          s_d.bus = ilf_pkg::BUS_ACK;
        end
      end
      ilf_pkg::BUS_ACK: s_d.bus = ilf_pkg::BUS_IDLE;
      default:          s_d.bus = ilf_pkg::BUS_IDLE;
    endcase
    s_d.syncA = pinIn;
    s_d.syncB = s_q.syncA;
    s_d.prevS = s_q.syncB;
    s_d.level = newLevel;

    if (wrFiltEn) begin
      s_d.filt = s_q.filt | wl;
    end
    if (wrFiltDis) begin
      s_d.filt = s_q.filt & ~wl;
    end
    if (wrDrvSet) begin
      s_d.drive = s_q.drive | wl;
    end
    if (wrDrvClr) begin
      s_d.drive = s_q.drive & ~wl;
    end
    if (wrDrvSt) begin
      s_d.drive = (s_q.drive & ~(s_q.perm & byteEn)) | (wl & s_q.perm);
    end
    if (wrEdge && wbReq.adr == ilf_pkg::OFS_PERM_EN) begin
      s_d.perm = s_q.perm | wl;
    end
    if (wrEdge && wbReq.adr == ilf_pkg::OFS_PERM_DIS) begin
      s_d.perm = s_q.perm & ~wl;
    end
    if (wrIrqEn) begin
      s_d.imask = s_q.imask | wl;
    end
    if (wrIrqDis) begin
      s_d.imask = s_q.imask & ~wl;
    end
    if (wrOdEn) begin
      s_d.multi = s_q.multi | wl;
    end
    if (wrEdge && wbReq.adr == ilf_pkg::OFS_OD_DIS) begin
      s_d.multi = s_q.multi & ~wl;
    end

    // A change in the reading cycle survives the clear
    s_d.flags = (rdFlags ? '0 : s_q.flags) | change;

    if (rdEdge) begin
      case (wbReq.adr)
        ilf_pkg::OFS_FILT_ST:   s_d.rdat = widen(s_q.filt);
        ilf_pkg::OFS_DRV_ST:    s_d.rdat = widen(s_q.drive);
        ilf_pkg::OFS_PIN_ST:    s_d.rdat = widen(s_q.level);
        ilf_pkg::OFS_IRQ_MASK:  s_d.rdat = widen(s_q.imask);
        ilf_pkg::OFS_IRQ_FLAGS: s_d.rdat = widen(s_q.flags);
        ilf_pkg::OFS_OD_ST:     s_d.rdat = widen(s_q.multi);
        ilf_pkg::OFS_PERM_ST:   s_d.rdat = widen(s_q.perm);
        default:                s_d.rdat = ilf_pkg::UNMAPPED_RD;
      endcase
    end

    // Open-drain lines never drive high: the enable carries the low level
    s_d.pout = s_d.drive & ~s_d.multi;
    s_d.poe  = lineOutputEn & (~s_d.multi | ~s_d.drive);
    s_d.irq  = |(s_d.flags & s_d.imask);
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_q       <= '0;
      s_q.bus   <= ilf_pkg::BUS_IDLE;
      s_q.rdat  <= ilf_pkg::RESET_ZERO;
    end else begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign wbRsp.ack = access & (s_q.bus == ilf_pkg::BUS_ACK);
  assign wbRsp.dat = s_q.rdat;
  assign pinOut    = s_q.pout;
  assign pinOe     = s_q.poe;
  assign irq       = s_q.irq;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  property p_filt_on;
    wrFiltEn |=> (s_q.filt == ($past(s_q.filt) | $past(wl)));
  endproperty
  a_filt_on: assert property (p_filt_on) else $error("filter enable write lost");

  property p_filt_off;
    wrFiltDis |=> ((s_q.filt & $past(wl)) == '0);
  endproperty
  a_filt_off: assert property (p_filt_off) else $error("filter disable write lost");

  property p_filt_read;
    (rdEdge && wbReq.adr == ilf_pkg::OFS_FILT_ST) |=>
      wbRsp.ack && wbRsp.dat == widen($past(s_q.filt));
  endproperty
  a_filt_read: assert property (p_filt_read) else $error("filter state read wrong");

  property p_drv_set_clr;
    (wrDrvSet |=> (s_q.drive & $past(wl)) == $past(wl)) and
    (wrDrvClr |=> (s_q.drive & $past(wl)) == '0);
  endproperty
  a_drv_set_clr: assert property (p_drv_set_clr) else $error("drive set/clear wrong");

  property p_drv_perm;
    (wrDrvSt && s_q.perm == '0) |=> $stable(s_q.drive);
  endproperty
  a_drv_perm: assert property (p_drv_perm) else $error("unpermitted drive write took");

  property p_pin_level;
    (s_q.filt == '0) [*3] |-> s_q.level == $past(pinIn, 3);
  endproperty
  a_pin_level: assert property (p_pin_level) else $error("pin level not sampled");

  property p_mask;
    wrIrqEn |=> ((s_q.imask & $past(wl)) == $past(wl)) ##1 1'b1;
  endproperty
  a_mask: assert property (p_mask) else $error("irq enable write lost");

  property p_flag_set;
    ((s_q.level ^ $past(s_q.level)) & ~s_q.flags) == '0;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("level change not flagged");

  property p_flag_clear;
    rdFlags |=> s_q.flags == (s_q.level ^ $past(s_q.level));
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flags not cleared on read");

  property p_irq;
    irq == |(s_q.flags & s_q.imask);
  endproperty
  a_irq: assert property (p_irq) else $error("irq does not follow flags and mask");

  property p_open_drain;
    (pinOut & s_q.multi) == '0;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("open-drain line high");

  property p_ack_once;
    access && s_q.bus == ilf_pkg::BUS_IDLE |=> wbRsp.ack ##1 !wbRsp.ack;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack not one cycle");

  // Read data and per-line register checks
  property p_filt_hold;
    (s_q.filt & ~stableS) != '0 |=>
      ((s_q.level ^ $past(s_q.level)) & $past(s_q.filt & ~stableS)) == '0;
  endproperty
  a_filt_hold: assert property (p_filt_hold) else $error("filtered glitch passed");

  property p_drv_keep;
    wrDrvSt |=> ((s_q.drive ^ $past(s_q.drive)) & ~$past(s_q.perm)) == '0;
  endproperty
  a_drv_keep: assert property (p_drv_keep) else $error("locked drive line changed");

  property p_drv_read;
    (rdEdge && wbReq.adr == ilf_pkg::OFS_DRV_ST) |=>
      wbRsp.dat == widen($past(s_q.drive));
  endproperty
  a_drv_read: assert property (p_drv_read) else $error("drive state read wrong");

  property p_pin_read;
    (rdEdge && wbReq.adr == ilf_pkg::OFS_PIN_ST) |=>
      wbRsp.dat == widen($past(s_q.level));
  endproperty
  a_pin_read: assert property (p_pin_read) else $error("pin state read wrong");

  property p_irq_off;
    wrIrqDis |=> (s_q.imask & $past(wl)) == '0;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq disable write lost");

  property p_mask_read;
    (rdEdge && wbReq.adr == ilf_pkg::OFS_IRQ_MASK) |=>
      wbRsp.dat == widen($past(s_q.imask));
  endproperty
  a_mask_read: assert property (p_mask_read) else $error("irq mask read wrong");

  property p_flag_read;
    rdFlags |=> wbRsp.dat == widen($past(s_q.flags));
  endproperty
  a_flag_read: assert property (p_flag_read) else $error("flags read wrong");

  // First edge out of reset: nothing may be pending
  property p_rst_clr;
    $fell(rst) |-> s_q.flags == '0 && !irq;
  endproperty
  a_rst_clr: assert property (p_rst_clr) else $error("flags left after reset");

  property p_od_on;
    wrOdEn |=> (s_q.multi & $past(wl)) == $past(wl);
  endproperty
  a_od_on: assert property (p_od_on) else $error("open-drain enable lost");

  c_write: cover property (wrDrvSet ##[1:20] wrDrvClr);
  c_flag_read: cover property (rdFlags && s_q.flags != '0);
  c_irq_rise: cover property ($rose(irq));
  c_glitch: cover property (s_q.filt != '0 && (s_q.syncB != s_q.prevS) ##1 $stable(s_q.level));

endmodule

// file: dv/ilf_pin_model.sv
`timescale 1ns/1ns

// Pad ring seen from the core: a driven line shows the core's level,
// an undriven line shows whatever the outside world puts there.
module ilf_pin_model #(
  parameter int LINES = 32
) (
  // Core side
  input  logic [LINES-1:0] pinOut,
  input  logic [LINES-1:0] pinOe,
  // Outside world
  input  logic [LINES-1:0] extLevel,
  output logic [LINES-1:0] pinIn
);
  // Open-drain lines drop their enable when high, so the outside level shows
  assign pinIn = (pinOe & pinOut) | (~pinOe & extLevel);
endmodule

// file: dv/io_line_filter_data_irq_bench.sv
`timescale 1ns/1ns

module io_line_filter_data_irq_bench;
  logic                 mclk = 1'b0;
  logic                 rst  = 1'b1;
  ilf_pkg::ilf_wb_req_s wbReq = '0;
  ilf_pkg::ilf_wb_rsp_s wbRsp;
  logic [31:0]          pinIn;
  logic [31:0]          lineOutputEn = '0;
  logic [31:0]          extLevel = '0;
  logic [31:0]          pinOut;
  logic [31:0]          pinOe;
  logic                 irq;
  logic [31:0]          junk;
  int                   fails = 0;
  int                   check_count = 0;

  always #4 mclk = ~mclk;

  ilf_gpio_core #(.LINES(32)) ilf_gpio_core_i (.mclk(mclk), .rst(rst), .wbReq(wbReq),
    .wbRsp(wbRsp), .pinIn(pinIn), .lineOutputEn(lineOutputEn), .pinOut(pinOut),
    .pinOe(pinOe), .irq(irq));
  ilf_pin_model #(.LINES(32)) ilf_pin_model_i (.pinOut(pinOut), .pinOe(pinOe),
    .extLevel(extLevel), .pinIn(pinIn));

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // One classic cycle; never assumes latency, only the watchdog ends a wait
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                    input logic [3:0] sel, output logic [31:0] rd);
    @(posedge mclk);
    wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: sel, dat: dat};
    do begin
      @(posedge mclk);
    end while (wbRsp.ack !== 1'b1);
    rd = wbRsp.dat;
    wbReq <= '0;
  endtask

  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    wb(1'b1, adr, dat, 4'hF, junk);
  endtask

  task automatic rdc(input logic [7:0] adr, input logic [31:0] exp);
    logic [31:0] v;
    wb(1'b0, adr, 32'h0000_0000, 4'hF, v);
    chk(v, exp);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_reset;
    rdc(ilf_pkg::OFS_FILT_ST, 32'h0000_0000);
    rdc(ilf_pkg::OFS_DRV_ST, 32'h0000_0000);
    rdc(ilf_pkg::OFS_IRQ_MASK, 32'h0000_0000);
    rdc(ilf_pkg::OFS_IRQ_FLAGS, 32'h0000_0000);
    rdc(ilf_pkg::OFS_FILT_EN, 32'h0000_0000);
    rdc(8'h10, 32'h0000_0000);
    chk({31'h0000_0000, irq}, 32'h0000_0000);
  endtask

  task automatic t_filter;
    wb(1'b1, ilf_pkg::OFS_FILT_EN, 32'hFFFF_FFFF, 4'h1, junk);
    wr(ilf_pkg::OFS_FILT_EN, 32'hA5A5_0000);
    wr(ilf_pkg::OFS_FILT_DIS, 32'h0000_00F0);
    wr(ilf_pkg::OFS_FILT_ST, 32'hFFFF_FFFF);
    wr(8'h10, 32'hFFFF_FFFF);
    rdc(ilf_pkg::OFS_FILT_ST, 32'hA5A5_000F);
    // Single-cycle pulse on a filtered and an unfiltered line
    @(posedge mclk);
    extLevel <= 32'h0000_0011;
    @(posedge mclk);
    extLevel <= 32'h0000_0000;
    settle(8);
    rdc(ilf_pkg::OFS_IRQ_FLAGS, 32'h0000_0010);
  endtask

  task automatic t_drive;
    @(posedge mclk);
    lineOutputEn <= 32'hFFFF_FFFF;
    wr(ilf_pkg::OFS_DRV_SET, 32'h0000_00FF);
    wr(ilf_pkg::OFS_DRV_CLR, 32'h0000_000F);
    rdc(ilf_pkg::OFS_DRV_ST, 32'h0000_00F0);
    chk(pinOut, 32'h0000_00F0);
    wr(ilf_pkg::OFS_DRV_ST, 32'hFFFF_0000);
    rdc(ilf_pkg::OFS_DRV_ST, 32'h0000_00F0);
    wr(ilf_pkg::OFS_PERM_EN, 32'h0F00_0000);
    wr(ilf_pkg::OFS_DRV_ST, 32'hFFFF_0000);
    rdc(ilf_pkg::OFS_DRV_ST, 32'h0F00_00F0);
    settle(6);
    rdc(ilf_pkg::OFS_PIN_ST, 32'h0F00_00F0);
    wr(ilf_pkg::OFS_PERM_DIS, 32'h0100_0000);
    rdc(ilf_pkg::OFS_PERM_ST, 32'h0E00_0000);
  endtask

  task automatic t_irq;
    @(posedge mclk);
    lineOutputEn <= 32'h0000_0000;
    settle(6);
    wb(1'b0, ilf_pkg::OFS_IRQ_FLAGS, 32'h0000_0000, 4'hF, junk);
    wr(ilf_pkg::OFS_IRQ_EN, 32'h0000_0300);
    wr(ilf_pkg::OFS_IRQ_DIS, 32'h0000_0100);
    rdc(ilf_pkg::OFS_IRQ_MASK, 32'h0000_0200);
    chk({31'h0000_0000, irq}, 32'h0000_0000);
    @(posedge mclk);
    extLevel <= 32'h0000_0300;
    settle(6);
    chk({31'h0000_0000, irq}, 32'h0000_0001);
    rdc(ilf_pkg::OFS_IRQ_FLAGS, 32'h0000_0300);
    rdc(ilf_pkg::OFS_IRQ_FLAGS, 32'h0000_0000);
    chk({31'h0000_0000, irq}, 32'h0000_0000);
  endtask

  task automatic t_open_drain;
    @(posedge mclk);
    lineOutputEn <= 32'hFFFF_FFFF;
    wr(ilf_pkg::OFS_OD_EN, 32'h0000_00F0);
    rdc(ilf_pkg::OFS_OD_ST, 32'h0000_00F0);
    chk(pinOut, 32'h0F00_0000);
    chk(pinOe, 32'hFFFF_FF0F);
    wr(ilf_pkg::OFS_DRV_CLR, 32'h0000_0030);
    // The enable is registered at the edge where the write lands
    @(posedge mclk);
    chk(pinOe, 32'hFFFF_FF3F);
    wr(ilf_pkg::OFS_OD_DIS, 32'h0000_0080);
    rdc(ilf_pkg::OFS_OD_ST, 32'h0000_0070);
    chk(pinOut, 32'h0F00_0080);
  endtask

  // Reset in mid-run drops pending flags and every setting
  task automatic t_reset_mid;
    chk({31'h0000_0000, irq}, 32'h0000_0001);
    @(posedge mclk);
    rst      <= 1'b1;
    extLevel <= 32'h0000_0000;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    rdc(ilf_pkg::OFS_IRQ_FLAGS, 32'h0000_0000);
    rdc(ilf_pkg::OFS_FILT_ST, 32'h0000_0000);
    rdc(ilf_pkg::OFS_OD_ST, 32'h0000_0000);
    rdc(ilf_pkg::OFS_IRQ_MASK, 32'h0000_0000);
    chk({31'h0000_0000, irq}, 32'h0000_0000);
  endtask

  // ---------------------------------------------------------------------------
  // Run control
  // ---------------------------------------------------------------------------
  task automatic close_out;
    $display("checks %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    t_reset();
    t_filter();
    t_drive();
    t_irq();
    t_open_drain();
    t_reset_mid();
    close_out();
  end

  // Whole sequence needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge mclk);
    fails++;
    close_out();
  end
endmodule
